// file: opf_defs.vh
`ifndef OPF_DEFS_VH
`define OPF_DEFS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define OPF_CLK_HZ 250000000
`define OPF_CLK_NS 4
`define OPF_LOCKOUT_GRACE_NS 50000
`define OPF_OVERLOAD_NS 118000000
`define OPF_SOFTSTART_NS 4800000
`define OPF_FSW_LO_HZ 65000
`define OPF_FSW_HI_HZ 100000
`define OPF_MAX_DUTY_PCT 80
`define OPF_PCT_FULL 100

// ----------------------------------------------------------------
// levels and counts
// ----------------------------------------------------------------
`define OPF_LVL_W 10
`define OPF_FEEDBACK_W 12
`define OPF_SS_FULL 10'h3FF
`define OPF_SS_ZERO 10'h000
`define OPF_FEEDBACK_SCALE 12'h003
`define OPF_HICCUP_ROUNDS 2'h2
`define OPF_SYNC_W 10

// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define OPF_ADDR_CTRL 8'h00
`define OPF_ADDR_STATUS 8'h04
`define OPF_ADDR_LEVEL 8'h08
`define OPF_CTRL_RST 2'h0
`define OPF_CTRL_LATCH_BIT 0
`define OPF_CTRL_FSEL_BIT 1
`define OPF_HTRANS_NONSEQ 2'h2
`define OPF_HTRANS_SEQ 2'h3

`endif

// file: opf_sync.v
module opf_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rstn_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_r;

	// two-stage synchroniser; first stage feeds only the second
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_r <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// file: opf_sequencer.v
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`include "opf_defs.vh"

//
// Operation
// - start source off at start, on at minimum
// - lockout drops gate; grace timer decides hiccup
// - overload, thermal, lockout, latch enter hiccup
// - hiccup: gate off, discharge, recharge, twice
// - soft-start on first start arrival from off, on second in hiccup
// - fault or latch at start keeps hiccup
// - latch cleared only by logic reset
// - latching variant: overload expiry sets latch
// - auto-retry variant restarts after hiccup
// - below guard level only guard current charges
// - soft-start ramps zero to full, holds
// - modulation is min of softstart, feedback/3
// - clock sets latch, current sense resets it
// - gate forced low at 80 percent period
// - modulation level never above full scale
// - overload timer runs during overload, expires
// - no pulses while feedback below skip threshold
// - switching clock 65 or 100 kHz
// - external latch stops gate, latched fault
module opf_sequencer #(
	parameter GRACE_CYC = `OPF_LOCKOUT_GRACE_NS / `OPF_CLK_NS,
	parameter OVERLOAD_CYC = `OPF_OVERLOAD_NS / `OPF_CLK_NS,
	parameter SOFTSTART_CYC = `OPF_SOFTSTART_NS / `OPF_CLK_NS,
	parameter PERIOD_LO_CYC = `OPF_CLK_HZ / `OPF_FSW_LO_HZ,
	parameter PERIOD_HI_CYC = `OPF_CLK_HZ / `OPF_FSW_HI_HZ
) (
	input wire REF_CLK_I,
	input wire RSTN_I,
	input wire SUP_START_I,
	input wire SUP_MIN_I,
	input wire SUP_LOCKOUT_I,
	input wire SUP_HICCUP_I,
	input wire SUP_GUARD_I,
	input wire FEEDBACK_SKIP_I,
	input wire FEEDBACK_OVERLOAD_I,
	input wire CS_TRIP_I,
	input wire THERMAL_I,
	input wire EXT_LATCH_I,
	input wire [`OPF_FEEDBACK_W-1:0] FEEDBACK_CODE_I,
	input wire HSEL_I,
	input wire [31:0] HADDR_I,
	input wire [1:0] HTRANS_I,
	input wire HWRITE_I,
	input wire [2:0] HSIZE_I,
	input wire [31:0] HWDATA_I,
	input wire HREADY_I,
	output reg [31:0] HRDATA_O,
	output reg HREADYOUT_O,
	output reg HRESP_O,
	output reg GATE_DRIVE_O,
	output reg STARTUP_EN_O,
	output reg GUARD_CHARGE_EN_O,
	output reg LOW_CURRENT_O,
	output reg [`OPF_LVL_W-1:0] MOD_LEVEL_O
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam ST_OFF = 5'h01;
	localparam ST_RUN = 5'h02;
	localparam ST_GRACE = 5'h04;
	localparam ST_HDIS = 5'h08;
	localparam ST_HCHG = 5'h10;

	localparam SS_STEP_CYC = SOFTSTART_CYC / `OPF_SS_FULL;
	localparam DUTY_LO_CYC = PERIOD_LO_CYC * `OPF_MAX_DUTY_PCT / `OPF_PCT_FULL;
	localparam DUTY_HI_CYC = PERIOD_HI_CYC * `OPF_MAX_DUTY_PCT / `OPF_PCT_FULL;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	wire [`OPF_SYNC_W-1:0] flags_s;
	wire [`OPF_FEEDBACK_W-1:0] fb_s;
	wire sup_start = flags_s[0];
	wire sup_min = flags_s[1];
	wire sup_lock = flags_s[2];
	wire sup_hic = flags_s[3];
	wire sup_guard = flags_s[4];
	wire fb_skip = flags_s[5];
	wire fb_ovl = flags_s[6];
	wire cs_trip = flags_s[7];
	wire thermal = flags_s[8];
	wire ext_latch = flags_s[9];

	opf_sync #(.W(`OPF_SYNC_W)) u_sync_flags (
		.clk_i(REF_CLK_I),
		.rstn_i(RSTN_I),
		.d_i({EXT_LATCH_I, THERMAL_I, CS_TRIP_I, FEEDBACK_OVERLOAD_I, FEEDBACK_SKIP_I,
			SUP_GUARD_I, SUP_HICCUP_I, SUP_LOCKOUT_I, SUP_MIN_I, SUP_START_I}),
		.q_o(flags_s)
	);

	opf_sync #(.W(`OPF_FEEDBACK_W)) u_sync_fb (
		.clk_i(REF_CLK_I),
		.rstn_i(RSTN_I),
		.d_i(FEEDBACK_CODE_I),
		.q_o(fb_s)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [4:0] st_r;
	reg [4:0] st_nxt;
	reg [1:0] hic_cnt_r;
	reg [1:0] hic_cnt_nxt;
	reg latched_r;
	reg [1:0] ctrl_r;
	reg [31:0] grace_r;
	reg [31:0] ovl_r;
	reg [31:0] ss_div_r;
	reg [`OPF_LVL_W-1:0] ss_r;
	reg [31:0] per_r;
	reg src_on_r;
	reg ss_restart;
	reg bus_wr_r;
	reg [7:0] bus_addr_r;

	wire latch_variant = ctrl_r[`OPF_CTRL_LATCH_BIT];
	wire fsel_hi = ctrl_r[`OPF_CTRL_FSEL_BIT];
	wire [31:0] period_cyc = fsel_hi ? PERIOD_HI_CYC : PERIOD_LO_CYC;
	wire [31:0] duty_cyc = fsel_hi ? DUTY_HI_CYC : DUTY_LO_CYC;
	wire ovl_expired = fb_ovl && (ovl_r >= OVERLOAD_CYC - 1);
	wire fault_now = thermal || ext_latch;
	wire latch_set = ext_latch || (ovl_expired && latch_variant);

	// ----------------------------------------------------------------
	// fault sequencer
	// ----------------------------------------------------------------
	always @* begin
		st_nxt = st_r;
		hic_cnt_nxt = hic_cnt_r;
		ss_restart = 1'b0;
		case (st_r)
			ST_OFF: begin
				if (fault_now || latched_r) begin
					st_nxt = ST_HDIS;
					hic_cnt_nxt = 2'h0;
				end else if (sup_start) begin
					st_nxt = ST_RUN;
					ss_restart = 1'b1;
				end
			end
			ST_RUN: begin
				if (fault_now || ovl_expired) begin
					st_nxt = ST_HDIS;
					hic_cnt_nxt = 2'h0;
				end else if (!sup_lock) begin
					st_nxt = ST_GRACE;
				end
			end
			ST_GRACE: begin
				if (fault_now || grace_r >= GRACE_CYC - 1) begin
					st_nxt = ST_HDIS;
					hic_cnt_nxt = 2'h0;
				end else if (sup_lock) begin
					st_nxt = ST_RUN;
				end
			end
			ST_HDIS: begin
				if (!sup_hic) begin
					st_nxt = ST_HCHG;
				end
			end
			ST_HCHG: begin
				if (sup_start) begin
					if (hic_cnt_r != `OPF_HICCUP_ROUNDS) begin
						hic_cnt_nxt = hic_cnt_r + 2'h1;
					end
					if (hic_cnt_r >= `OPF_HICCUP_ROUNDS - 2'h1 && !fault_now && !latched_r) begin
						st_nxt = ST_RUN;
						ss_restart = 1'b1;
					end else begin
						st_nxt = ST_HDIS;
					end
				end
			end
			default: begin
				st_nxt = ST_OFF;
			end
		endcase
	end

	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			st_r <= ST_OFF;
			hic_cnt_r <= 2'h0;
			latched_r <= 1'b0;
			grace_r <= 32'h0;
			ovl_r <= 32'h0;
		end else begin
			st_r <= st_nxt;
			hic_cnt_r <= hic_cnt_nxt;
			if (latch_set) begin
				latched_r <= 1'b1;
			end
			grace_r <= (st_r == ST_GRACE) ? grace_r + 32'h1 : 32'h0;
			if (st_r == ST_RUN && fb_ovl) begin
				ovl_r <= ovl_r + 32'h1;
			end else begin
				ovl_r <= 32'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// supply source control
	// ----------------------------------------------------------------
	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			src_on_r <= 1'b1;
			STARTUP_EN_O <= 1'b0;
			GUARD_CHARGE_EN_O <= 1'b1;
			LOW_CURRENT_O <= 1'b0;
		end else begin
			if (sup_start) begin
				src_on_r <= 1'b0;
			end else if (!sup_min) begin
				src_on_r <= 1'b1;
			end
			GUARD_CHARGE_EN_O <= !sup_guard;
			case (st_nxt)
				ST_HDIS: begin
					STARTUP_EN_O <= 1'b0;
					LOW_CURRENT_O <= 1'b1;
				end
				ST_HCHG: begin
					STARTUP_EN_O <= sup_guard;
					LOW_CURRENT_O <= 1'b1;
				end
				default: begin
					STARTUP_EN_O <= sup_guard && src_on_r && !sup_start;
					LOW_CURRENT_O <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// soft-start ramp and modulation level
	// ----------------------------------------------------------------
	wire [`OPF_FEEDBACK_W-1:0] fb_div = fb_s / `OPF_FEEDBACK_SCALE;
	wire fb_over = fb_div > {2'h0, `OPF_SS_FULL};
	wire [`OPF_LVL_W-1:0] fb_lvl = fb_over ? `OPF_SS_FULL : fb_div[`OPF_LVL_W-1:0];
	wire [`OPF_LVL_W-1:0] mod_nxt = (ss_r < fb_lvl) ? ss_r : fb_lvl;

	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			ss_r <= `OPF_SS_ZERO;
			ss_div_r <= 32'h0;
			MOD_LEVEL_O <= `OPF_SS_ZERO;
		end else begin
			if (ss_restart) begin
				ss_r <= `OPF_SS_ZERO;
				ss_div_r <= 32'h0;
			end else if (ss_r != `OPF_SS_FULL) begin
				if (ss_div_r >= SS_STEP_CYC - 1) begin
					ss_div_r <= 32'h0;
					ss_r <= ss_r + 10'h001;
				end else begin
					ss_div_r <= ss_div_r + 32'h1;
				end
			end
			MOD_LEVEL_O <= mod_nxt;
		end
	end

	// ----------------------------------------------------------------
	// switching clock and output latch
	// ----------------------------------------------------------------
	wire per_start = (per_r == 32'h0);

	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			per_r <= 32'h0;
			GATE_DRIVE_O <= 1'b0;
		end else begin
			per_r <= (per_r >= period_cyc - 1) ? 32'h0 : per_r + 32'h1;
			if (st_nxt != ST_RUN || st_r != ST_RUN) begin
				GATE_DRIVE_O <= 1'b0;
			end else if (per_r >= duty_cyc - 1) begin
				GATE_DRIVE_O <= 1'b0;
			end else if (per_start) begin
				GATE_DRIVE_O <= fb_skip && !cs_trip;
			end else if (cs_trip) begin
				GATE_DRIVE_O <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite register slave
	// ----------------------------------------------------------------
	wire bus_go = HSEL_I && HREADY_I &&
		(HTRANS_I == `OPF_HTRANS_NONSEQ || HTRANS_I == `OPF_HTRANS_SEQ);
	wire [31:0] status_w = {19'h0, st_r, 1'b0, GATE_DRIVE_O, hic_cnt_r, latched_r,
		STARTUP_EN_O, LOW_CURRENT_O, fb_skip};

	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			ctrl_r <= `OPF_CTRL_RST;
			bus_wr_r <= 1'b0;
			bus_addr_r <= 8'h00;
			HRDATA_O <= 32'h0;
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			bus_wr_r <= bus_go && HWRITE_I;
			bus_addr_r <= HADDR_I[7:0];
			if (bus_wr_r && bus_addr_r == `OPF_ADDR_CTRL) begin
				ctrl_r <= HWDATA_I[1:0];
			end
			if (bus_go && !HWRITE_I) begin
				case (HADDR_I[7:0])
					`OPF_ADDR_CTRL: HRDATA_O <= {30'h0, ctrl_r};
					`OPF_ADDR_STATUS: HRDATA_O <= status_w;
					`OPF_ADDR_LEVEL: HRDATA_O <= {6'h0, ss_r, 6'h0, MOD_LEVEL_O};
					default: HRDATA_O <= 32'h0;
				endcase
			end
		end
	end
endmodule

// file: opf_sequencer_checker.sv
`include "opf_defs.vh"

module opf_sequencer_checker #(
	parameter PERIOD_LO_CYC = 20
) (
	input wire REF_CLK_I,
	input wire RSTN_I,
	input wire SUP_LOCKOUT_I,
	input wire SUP_GUARD_I,
	input wire FEEDBACK_SKIP_I,
	input wire CS_TRIP_I,
	input wire THERMAL_I,
	input wire [`OPF_FEEDBACK_W-1:0] FEEDBACK_CODE_I,
	input wire GATE_DRIVE_O,
	input wire STARTUP_EN_O,
	input wire GUARD_CHARGE_EN_O,
	input wire LOW_CURRENT_O,
	input wire [`OPF_LVL_W-1:0] MOD_LEVEL_O
);
	timeunit 1ns;
	timeprecision 1ps;
	// -----------
	// checks
	// -----------
	localparam int DUTY_MAX = PERIOD_LO_CYC * `OPF_MAX_DUTY_PCT / `OPF_PCT_FULL;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	logic [15:0] hi_cnt;
	// length of the current gate pulse
	always @(posedge REF_CLK_I) begin
		if (!RSTN_I || !GATE_DRIVE_O) hi_cnt <= 16'h0000;
		else hi_cnt <= hi_cnt + 16'h0001;
	end
	lockout_drop_a: assert property (!SUP_LOCKOUT_I[*5] |-> !GATE_DRIVE_O)
		else $error("gate on during lockout");
	guard_only_a: assert property (!SUP_GUARD_I[*5] |-> GUARD_CHARGE_EN_O && !STARTUP_EN_O)
		else $error("wrong source below guard level");
	hiccup_gate_a: assert property (LOW_CURRENT_O[*2] |-> !GATE_DRIVE_O)
		else $error("gate on in low current mode");
	thermal_off_a: assert property (THERMAL_I[*5] |-> !GATE_DRIVE_O)
		else $error("gate on during thermal fault");
	skip_hold_a: assert property (!FEEDBACK_SKIP_I[*5] |-> !$rose(GATE_DRIVE_O))
		else $error("pulse while below skip threshold");
	cs_reset_a: assert property (CS_TRIP_I[*5] |-> !GATE_DRIVE_O)
		else $error("gate on after current trip");
	duty_limit_a: assert property (hi_cnt <= DUTY_MAX)
		else $error("pulse longer than duty limit");
	mod_bound_a: assert property ($stable(FEEDBACK_CODE_I)[*5] |-> MOD_LEVEL_O <= FEEDBACK_CODE_I / 3)
		else $error("modulation above feedback share");
	cover property ($rose(GATE_DRIVE_O));
	cover property ($rose(LOW_CURRENT_O));
	cover property ($fell(GUARD_CHARGE_EN_O));
endmodule

bind opf_sequencer opf_sequencer_checker #(.PERIOD_LO_CYC(PERIOD_LO_CYC)) u_chk (
	.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .SUP_LOCKOUT_I(SUP_LOCKOUT_I),
	.SUP_GUARD_I(SUP_GUARD_I), .FEEDBACK_SKIP_I(FEEDBACK_SKIP_I), .CS_TRIP_I(CS_TRIP_I),
	.THERMAL_I(THERMAL_I), .FEEDBACK_CODE_I(FEEDBACK_CODE_I), .GATE_DRIVE_O(GATE_DRIVE_O),
	.STARTUP_EN_O(STARTUP_EN_O), .GUARD_CHARGE_EN_O(GUARD_CHARGE_EN_O),
	.LOW_CURRENT_O(LOW_CURRENT_O), .MOD_LEVEL_O(MOD_LEVEL_O));

// file: opf_sequencer_bench.sv
`include "opf_defs.vh"

module opf_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, st = 0, mn = 0, lk = 0, hc = 0, gd = 0, skp = 1, ovl = 0;
	logic cs = 0, th = 0, xl = 0, hsel = 0, hwr = 0;
	logic [11:0] fbc = 12'hFFF;
	logic [31:0] ha = 0, hwd = 0;
	logic [2:0] hsz = 0;
	logic [1:0] htr = 0;
	wire [31:0] hrd;
	wire hro, hrsp, gate, sen, gce, lc;
	wire [9:0] mod;
	int err_count = 0, n_compared = 0;
	always #2 clk = ~clk;
	opf_sequencer #(.GRACE_CYC(20), .OVERLOAD_CYC(200), .SOFTSTART_CYC(2046),
		.PERIOD_LO_CYC(20), .PERIOD_HI_CYC(10)) DUT (
		.REF_CLK_I(clk), .RSTN_I(rstn), .SUP_START_I(st), .SUP_MIN_I(mn),
		.SUP_LOCKOUT_I(lk), .SUP_HICCUP_I(hc), .SUP_GUARD_I(gd), .FEEDBACK_SKIP_I(skp),
		.FEEDBACK_OVERLOAD_I(ovl), .CS_TRIP_I(cs), .THERMAL_I(th), .EXT_LATCH_I(xl),
		.FEEDBACK_CODE_I(fbc), .HSEL_I(hsel), .HADDR_I(ha), .HTRANS_I(htr), .HWRITE_I(hwr),
		.HSIZE_I(hsz), .HWDATA_I(hwd), .HREADY_I(hro), .HRDATA_O(hrd), .HREADYOUT_O(hro),
		.HRESP_O(hrsp), .GATE_DRIVE_O(gate), .STARTUP_EN_O(sen), .GUARD_CHARGE_EN_O(gce),
		.LOW_CURRENT_O(lc), .MOD_LEVEL_O(mod));
	// -----------
	// tasks
	// -----------
	task end_of_test;
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task hang;
		err_count++;
		$display("BAD %0t wait ran out", $time);
		end_of_test;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task waitrdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hro !== 1'b1 && n < 50);
		if (n >= 50) hang;
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1;
		htr <= `OPF_HTRANS_NONSEQ;
		ha <= a;
		hwr <= w;
		hsz <= 3'h2;
		waitrdy;
		hsel <= 0;
		htr <= 2'h0;
		hwd <= d;
		waitrdy;
		q = hrd;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(0, a, 0, q);
		chk(q & m, e);
		chk(hrsp, 0);
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask
	task state(input logic [4:0] e);
		rd(`OPF_ADDR_STATUS, 32'h1F00, {19'h0, e, 8'h00});
	endtask
	task sup(input logic s, input logic m, input logic l, input logic h);
		st <= s;
		mn <= m;
		lk <= l;
		hc <= h;
		cyc(8);
	endtask
	task round;
		sup(0, 0, 0, 0);
		sup(1, 1, 1, 1);
	endtask
	task rise(output int n);
		n = 0;
		while (gate !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		while (gate !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) hang;
	endtask
	task quiet;
		// let a pulse already under way run out first
		cyc(22);
		repeat (40) begin
			@(posedge clk);
			chk(gate, 0);
		end
	endtask
	// -----------
	// sequence
	// -----------
	initial begin
		int n;
		cyc(16);
		rstn <= 1;
		cyc(2);
		chk({gce, sen}, 2'h2);
		rd(`OPF_ADDR_CTRL, 32'h3, 0);
		rd(32'h10, 32'hFFFFFFFF, 0);
		gd <= 1;
		cyc(8);
		chk({gce, sen}, 2'h1);
		wr(`OPF_ADDR_CTRL, 2);
		rd(`OPF_ADDR_CTRL, 32'h3, 2);
		sup(1, 1, 1, 1);
		chk(sen, 0);
		st <= 0;
		cyc(8);
		chk(sen, 0);
		mn <= 0;
		cyc(8);
		chk(sen, 1);
		sup(1, 1, 1, 1);
		chk(sen, 0);
		state(5'h02);
		rise(n);
		rise(n);
		chk(n, 10);
		wr(`OPF_ADDR_CTRL, 0);
		rise(n);
		rise(n);
		chk(n, 20);
		fbc <= 12'h030;
		cyc(2100);
		rd(`OPF_ADDR_LEVEL, 32'h03FF03FF, 32'h03FF0010);
		fbc <= 12'hFFF;
		cyc(8);
		chk(mod, 10'h3FF);
		skp <= 0;
		quiet;
		skp <= 1;
		cs <= 1;
		quiet;
		cs <= 0;
		lk <= 0;
		cyc(5);
		chk(gate, 0);
		lk <= 1;
		cyc(8);
		state(5'h02);
		sup(0, 0, 0, 1);
		cyc(40);
		state(5'h08);
		chk({lc, sen, gate}, 3'h4);
		round;
		rd(`OPF_ADDR_STATUS, 32'h1F30, 32'h0810);
		round;
		state(5'h02);
		ovl <= 1;
		cyc(260);
		rd(`OPF_ADDR_STATUS, 32'h1F38, 32'h0800);
		ovl <= 0;
		round;
		round;
		state(5'h02);
		th <= 1;
		cyc(8);
		round;
		round;
		state(5'h08);
		th <= 0;
		round;
		state(5'h02);
		wr(`OPF_ADDR_CTRL, 1);
		ovl <= 1;
		cyc(260);
		rd(`OPF_ADDR_STATUS, 32'h08, 32'h08);
		ovl <= 0;
		round;
		round;
		state(5'h08);
		rstn <= 0;
		cyc(4);
		rstn <= 1;
		cyc(8);
		rd(`OPF_ADDR_STATUS, 32'h38, 0);
		xl <= 1;
		cyc(8);
		rd(`OPF_ADDR_STATUS, 32'h1F08, 32'h0808);
		end_of_test;
	end
endmodule
